/* common/ext_irq_pkg.sv */
// package: register map, field layout and trigger encodings for external pins
package ext_irq_pkg;
  localparam int          NUM_SRC      = 16;
  localparam int          ADDR_W       = 3;
  localparam int          DATA_W       = 8;
  localparam logic [2:0]  ADDR_TSEL0   = 3'h0;
  localparam logic [2:0]  ADDR_TSEL1   = 3'h1;
  localparam logic [2:0]  ADDR_TSEL2   = 3'h2;
  localparam logic [2:0]  ADDR_TSEL3   = 3'h3;
  localparam logic [2:0]  ADDR_PEN_LO  = 3'h4;
  localparam logic [2:0]  ADDR_PEN_HI  = 3'h5;
  localparam logic [2:0]  ADDR_FLG_LO  = 3'h6;
  localparam logic [2:0]  ADDR_FLG_HI  = 3'h7;
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  // writable source positions of each enable register
  localparam logic [15:0] ENABLE_MASK  = 16'hfefc;
  // sources that exist at all; source 8 has no logic
  localparam logic [15:0] SOURCE_MASK  = 16'hfeff;
  // sources whose flags clear on core response
  localparam logic [15:0] ACK_MASK     = 16'h0003;
  // sources gated by a port enable
  localparam logic [15:0] GATED_MASK   = 16'hfefc;
  localparam logic [15:0] GROUP_A_MASK = 16'h00fc;
  localparam logic [15:0] GROUP_B_MASK = 16'hfe00;

  typedef enum logic [1:0]
  {
    TRIG_LOW     = 2'h0,
    TRIG_FALL    = 2'h1,
    TRIG_RISE    = 2'h2,
    TRIG_BOTH    = 2'h3
  } trigger_kind_t;

  typedef struct packed
  {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;
endpackage

/* hw/ext_irq_flags.sv */
// external interrupt trigger selection, port enables and request flags
//
// The strobed register port and the register offsets were decided locally.
module ext_irq_flags
  import ext_irq_pkg::*;
(
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST,
  input  wire logic [NUM_SRC-1:0]    PIN_IN,
  input  wire logic [ADDR_W-1:0]     ADDR,
  input  wire logic [DATA_W-1:0]     WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  input  wire logic                  ACK_SRC0,
  input  wire logic                  ACK_SRC1,
  input  wire logic                  GROUP_A_VECTOR_ENABLE,
  input  wire logic                  GROUP_B_VECTOR_ENABLE,
  output logic      [DATA_W-1:0]     RDATA,
  output logic      [NUM_SRC-1:0]    FLAGS,
  output logic                       REQ_SRC0,
  output logic                       REQ_SRC1,
  output logic                       REQ_GROUP_A,
  output logic                       REQ_GROUP_B
);

  reg_req_t                 req;
  logic [2*NUM_SRC-1:0]     tsel_reg;
  logic [2*NUM_SRC-1:0]     tsel_next;
  logic [NUM_SRC-1:0]       enable_reg;
  logic [NUM_SRC-1:0]       enable_next;
  logic [NUM_SRC-1:0]       flag_reg;
  logic [NUM_SRC-1:0]       flag_next;
  logic [NUM_SRC-1:0]       pin_reg;
  logic [NUM_SRC-1:0]       prev_reg;
  logic [NUM_SRC-1:0]       trig;
  logic [NUM_SRC-1:0]       sw_clear;
  logic [NUM_SRC-1:0]       ack_vec;
  logic [DATA_W-1:0]        rdata_next;
  logic                     req_a_next;
  logic                     req_b_next;

  assign req = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};
  assign ack_vec = {{(NUM_SRC-2){1'b0}}, ACK_SRC1, ACK_SRC0};

  // trigger condition per source; pins are sampled once so edges compare
  // two registered copies and never the raw input
  generate
    for (genvar i = 0; i < NUM_SRC; i++)
    begin : g_src
      trigger_kind_t kind;
      assign kind = trigger_kind_t'(tsel_reg[2*i +: 2]);
      always_comb
      begin
        unique case (kind)
          TRIG_LOW:  trig[i] = ~pin_reg[i];
          TRIG_FALL: trig[i] = prev_reg[i] & ~pin_reg[i];
          TRIG_RISE: trig[i] = ~prev_reg[i] & pin_reg[i];
          TRIG_BOTH: trig[i] = prev_reg[i] ^ pin_reg[i];
        endcase
      end
    end
  endgenerate

  always_comb
  begin
    tsel_next   = tsel_reg;
    enable_next = enable_reg;
    sw_clear    = '0;
    if (req.wr)
    begin
      unique case (req.addr)
        ADDR_TSEL0:  tsel_next[7:0]   = req.wdata;
        ADDR_TSEL1:  tsel_next[15:8]  = req.wdata;
        ADDR_TSEL2:  tsel_next[23:18] = req.wdata[7:2];
        ADDR_TSEL3:  tsel_next[31:24] = req.wdata;
        ADDR_PEN_LO: enable_next[7:0] =
                       req.wdata & ENABLE_MASK[7:0];
        ADDR_PEN_HI: enable_next[15:8] =
                       req.wdata & ENABLE_MASK[15:8];
        ADDR_FLG_LO: sw_clear[7:0]    = ~req.wdata;
        ADDR_FLG_HI: sw_clear[15:8]   = ~req.wdata;
      endcase
    end
  end

  // writing one to a flag does nothing; a new trigger beats a clear in
  // the same cycle so no event is lost
  always_comb
  begin
    flag_next = flag_reg & ~sw_clear & ~(ack_vec & ACK_MASK);
    flag_next = flag_next
              | (trig & SOURCE_MASK & ~GATED_MASK)
              | (trig & enable_reg & GATED_MASK);
  end

  always_comb
  begin
    rdata_next = RESET_BYTE;
    if (req.rd)
    begin
      unique case (req.addr)
        ADDR_TSEL0:  rdata_next = tsel_reg[7:0];
        ADDR_TSEL1:  rdata_next = tsel_reg[15:8];
        ADDR_TSEL2:  rdata_next = {tsel_reg[23:18], 2'h0};
        ADDR_TSEL3:  rdata_next = tsel_reg[31:24];
        ADDR_PEN_LO: rdata_next = enable_reg[7:0] & ENABLE_MASK[7:0];
        ADDR_PEN_HI: rdata_next = enable_reg[15:8];
        ADDR_FLG_LO: rdata_next = flag_reg[7:0];
        ADDR_FLG_HI: rdata_next = flag_reg[15:8];
      endcase
    end
  end

  // flags of a group combine onto one request, gated by the group enable
  always_comb
  begin
    req_a_next = GROUP_A_VECTOR_ENABLE
               & (|(flag_reg & GROUP_A_MASK));
    req_b_next = GROUP_B_VECTOR_ENABLE
               & (|(flag_reg & GROUP_B_MASK));
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      tsel_reg    <= '0;
      enable_reg  <= '0;
      flag_reg    <= '0;
      pin_reg     <= '1;
      prev_reg    <= '1;
      RDATA       <= RESET_BYTE;
      FLAGS       <= '0;
      REQ_SRC0    <= 1'b0;
      REQ_SRC1    <= 1'b0;
      REQ_GROUP_A <= 1'b0;
      REQ_GROUP_B <= 1'b0;
    end
    else
    begin
      tsel_reg    <= tsel_next;
      enable_reg  <= enable_next;
      flag_reg    <= flag_next;
      pin_reg     <= PIN_IN;
      prev_reg    <= pin_reg;
      RDATA       <= rdata_next;
      FLAGS       <= flag_next;
      REQ_SRC0    <= flag_next[0];
      REQ_SRC1    <= flag_next[1];
      REQ_GROUP_A <= req_a_next;
      REQ_GROUP_B <= req_b_next;
    end
  end

  sequence s_fall(int i);
    prev_reg[i] && !pin_reg[i];
  endsequence

  property p_fall_sets;
    @(posedge CLK_SYS) disable iff (RST)
    (tsel_reg[1:0] == TRIG_FALL) ##0 s_fall(0) |=> flag_reg[0];
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("falling edge did not set flag 0");

  property p_rise_sets;
    @(posedge CLK_SYS) disable iff (RST)
    (tsel_reg[5:4] == TRIG_RISE) && !prev_reg[2] && pin_reg[2]
      && enable_reg[2] |=> flag_reg[2];
  endproperty
  a_rise_sets: assert property (p_rise_sets)
    else $error("rising edge did not set enabled flag 2");

  property p_disabled_hold;
    @(posedge CLK_SYS) disable iff (RST)
    !enable_reg[3] && !flag_reg[3] |=> !flag_reg[3];
  endproperty
  a_disabled_hold: assert property (p_disabled_hold)
    else $error("disabled source 3 set its flag");

  property p_reserved_zero;
    @(posedge CLK_SYS) disable iff (RST)
    req.rd && req.addr == ADDR_PEN_LO |=> RDATA[1:0] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved enable bits read nonzero");

  property p_ack_clears;
    @(posedge CLK_SYS) disable iff (RST)
    ACK_SRC0 && !trig[0] |=> !flag_reg[0];
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("response did not clear flag 0");

  property p_ack_ignored;
    @(posedge CLK_SYS) disable iff (RST)
    flag_reg[4] && !(req.wr && req.addr == ADDR_FLG_LO)
      |=> flag_reg[4];
  endproperty
  a_ack_ignored: assert property (p_ack_ignored)
    else $error("flag 4 cleared without software write");

  property p_sw_clear_hi;
    @(posedge CLK_SYS) disable iff (RST)
    req.wr && req.addr == ADDR_FLG_HI && !req.wdata[1] && !trig[9]
      |=> !flag_reg[9];
  endproperty
  a_sw_clear_hi: assert property (p_sw_clear_hi)
    else $error("software write did not clear flag 9");

  property p_group_a;
    @(posedge CLK_SYS) disable iff (RST)
    GROUP_A_VECTOR_ENABLE && flag_reg[5] |=> REQ_GROUP_A;
  endproperty
  a_group_a: assert property (p_group_a)
    else $error("group a request missing");

  property p_src8_none;
    @(posedge CLK_SYS) disable iff (RST)
    1'b1 |-> !flag_reg[8] && !enable_reg[8];
  endproperty
  a_src8_none: assert property (p_src8_none)
    else $error("source 8 logic active");

  sequence s_edge(int i);
    prev_reg[i] != pin_reg[i];
  endsequence

  sequence s_low(int i);
    !pin_reg[i];
  endsequence

  property p_both_sets;
    @(posedge CLK_SYS) disable iff (RST)
    (tsel_reg[3:2] == TRIG_BOTH) ##0 s_edge(1) |=> flag_reg[1];
  endproperty
  a_both_sets: assert property (p_both_sets)
    else $error("double edge did not set flag 1");

  property p_level_sets;
    @(posedge CLK_SYS) disable iff (RST)
    (tsel_reg[1:0] == TRIG_LOW) ##0 s_low(0) |=> flag_reg[0];
  endproperty
  a_level_sets: assert property (p_level_sets)
    else $error("low level did not set flag 0");

  property p_level_gated;
    @(posedge CLK_SYS) disable iff (RST)
    (tsel_reg[25:24] == TRIG_LOW) && !pin_reg[12] && enable_reg[12]
      |=> flag_reg[12];
  endproperty
  a_level_gated: assert property (p_level_gated)
    else $error("enabled low level did not set flag 12");

  property p_enable_lo;
    @(posedge CLK_SYS) disable iff (RST)
    req.wr && req.addr == ADDR_PEN_LO
      |=> enable_reg[7:2] == $past(req.wdata[7:2]);
  endproperty
  a_enable_lo: assert property (p_enable_lo)
    else $error("low enable write not stored");

  property p_enable_hi;
    @(posedge CLK_SYS) disable iff (RST)
    req.wr && req.addr == ADDR_PEN_HI
      |=> enable_reg[15:9] == $past(req.wdata[7:1]);
  endproperty
  a_enable_hi: assert property (p_enable_hi)
    else $error("high enable write not stored");

  property p_enable_reserved;
    @(posedge CLK_SYS) disable iff (RST)
    1'b1 |-> enable_reg[1:0] == 2'h0;
  endproperty
  a_enable_reserved: assert property (p_enable_reserved)
    else $error("reserved enable bits stored");

  property p_sw_clear_lo;
    @(posedge CLK_SYS) disable iff (RST)
    req.wr && req.addr == ADDR_FLG_LO && !req.wdata[4] && !trig[4]
      |=> !flag_reg[4];
  endproperty
  a_sw_clear_lo: assert property (p_sw_clear_lo)
    else $error("software write did not clear flag 4");

  property p_write_one_keeps;
    @(posedge CLK_SYS) disable iff (RST)
    flag_reg[9] && req.wr && req.addr == ADDR_FLG_HI && req.wdata[1]
      |=> flag_reg[9];
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps)
    else $error("writing one cleared flag 9");

  property p_ack1_clears;
    @(posedge CLK_SYS) disable iff (RST)
    ACK_SRC1 && !trig[1] |=> !flag_reg[1];
  endproperty
  a_ack1_clears: assert property (p_ack1_clears)
    else $error("response did not clear flag 1");

  property p_src_req;
    @(posedge CLK_SYS) disable iff (RST)
    1'b1 |-> REQ_SRC0 == flag_reg[0]
      && REQ_SRC1 == flag_reg[1];
  endproperty
  a_src_req: assert property (p_src_req)
    else $error("source request differs from its flag");

  property p_group_b;
    @(posedge CLK_SYS) disable iff (RST)
    GROUP_B_VECTOR_ENABLE && flag_reg[9] |=> REQ_GROUP_B;
  endproperty
  a_group_b: assert property (p_group_b)
    else $error("group b request missing");

  property p_group_a_off;
    @(posedge CLK_SYS) disable iff (RST)
    !GROUP_A_VECTOR_ENABLE |=> !REQ_GROUP_A;
  endproperty
  a_group_a_off: assert property (p_group_a_off)
    else $error("group a request while group disabled");

  property p_reset_zero;
    @(posedge CLK_SYS)
    RST |=> FLAGS == '0 && RDATA == RESET_BYTE && tsel_reg == '0
      && !REQ_GROUP_A && !REQ_GROUP_B;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("state not zero after reset");

  property p_tsel2_reserved;
    @(posedge CLK_SYS) disable iff (RST)
    req.rd && req.addr == ADDR_TSEL2 |=> RDATA[1:0] == 2'h0;
  endproperty
  a_tsel2_reserved: assert property (p_tsel2_reserved)
    else $error("source 8 select slot reads nonzero");

  property p_pin_prev;
    @(posedge CLK_SYS) disable iff (RST)
    1'b1 |=> prev_reg == $past(pin_reg);
  endproperty
  a_pin_prev: assert property (p_pin_prev)
    else $error("previous pin sample not kept");

endmodule

/* tb/ext_irq_flags_tb_top.sv */
// self-checking bench for the external interrupt flag block
module ext_irq_flags_tb_top
  import ext_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_sys = 0, rst = 1, wr = 0, rd = 0;
  logic               ack0 = 0, rd_seen = 0;
  logic               ack1 = 0, gea = 1, geb = 1;
  logic               req0, req1, reqa, reqb;
  logic [NUM_SRC-1:0] flags;
  logic [ADDR_W-1:0]  addr = '0;
  logic [DATA_W-1:0]  wdata = '0, rdata, v, w;
  logic [NUM_SRC-1:0] want = '1, pins;
  logic [DATA_W-1:0]  expq[$];
  logic [DATA_W-1:0]  mask[8] = '{8'hff, 8'hff, 8'hfc, 8'hff,
                                  8'hfc, 8'hfe, 8'h00, 8'h00};
  logic [2:0]         ta[2] = '{3'h0, 3'h2}, pa[2] = '{3'h4, 3'h5};
  logic [2:0]         fa[2] = '{3'h6, 3'h7};
  logic [7:0]         b[2] = '{8'h08, 8'h04};
  int                 sh[2] = '{6, 4}, src[2] = '{3, 10};
  int                 errors = 0, compares = 0, seed = 3445;

  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  ext_pin_model ext_pin_model_inst (.clk(clk_sys), .want(want), .pins(pins));

  ext_irq_flags ext_irq_flags_inst (
    .CLK_SYS(clk_sys), .RST(rst), .PIN_IN(pins), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .ACK_SRC0(ack0), .ACK_SRC1(ack1),
    .GROUP_A_VECTOR_ENABLE(gea), .GROUP_B_VECTOR_ENABLE(geb),
    .RDATA(rdata), .FLAGS(flags), .REQ_SRC0(req0), .REQ_SRC1(req1),
    .REQ_GROUP_A(reqa), .REQ_GROUP_B(reqb));

  // level outputs are looked at mid-cycle, well clear of the edge
  task automatic look(input logic [19:0] e);
    @(negedge clk_sys);
    compares++;
    if ({req1, req0, reqa, reqb, flags} !== e)
    begin
      errors++;
      $display("BAD %0t outputs %h expected %h", $time,
               {req1, req0, reqa, reqb, flags}, e);
    end
  endtask

  task automatic put(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic get(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    expq.push_back(e);
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // read data stands only in the cycle after the strobe: look mid-cycle
  always @(posedge clk_sys) rd_seen <= rd;
  always @(negedge clk_sys)
  begin
    if (rd_seen)
    begin
      w = expq.pop_front();
      compares++;
      if (rdata !== w)
      begin
        errors++;
        $display("BAD %0t read %h expected %h", $time, rdata, w);
      end
    end
  end

  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) get(3'(a), RESET_BYTE);
    // pins stay high here, so random selects and enables set no flag
    for (int i = 0; i < 16; i++)
    begin
      v = 8'($random(seed));
      put(3'(i), v);
      get(3'(i), v & mask[i % 8]);
    end
    for (int k = 0; k < 2; k++)
      for (int m = 0; m < 4; m++)
      begin
        put(ta[k], 8'(m << sh[k]));
        put(pa[k], b[k]);
        want[src[k]] <= 1'b0;
        gea <= m != 3;
        geb <= m != 3;
        repeat (4) @(posedge clk_sys);
        get(fa[k], m != 2 ? b[k] : 8'h00);
        look({2'b00, k == 0 && m < 2, k == 1 && m < 2,
              (m != 2) ? 16'(1 << src[k]) : 16'h0000});
        // disable, clear, re-enable: a level trigger sets again
        put(pa[k], 8'h00);
        put(fa[k], 8'h00);
        put(pa[k], b[k]);
        want[src[k]] <= 1'b1;
        repeat (4) @(posedge clk_sys);
        get(fa[k], m != 1 ? b[k] : 8'h00);
        put(fa[k], 8'h00);
        get(fa[k], 8'h00);
      end
    put(3'h4, 8'h00);
    want[3] <= 1'b0;
    repeat (4) @(posedge clk_sys);
    want[3] <= 1'b1;
    want[0] <= 1'b0;
    want[1] <= 1'b0;
    repeat (4) @(posedge clk_sys);
    want[0] <= 1'b1;
    want[1] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    get(3'h6, 8'h03);
    look({2'b11, 2'b00, 16'h0003});
    @(posedge clk_sys);
    ack0 <= 1'b1;
    @(posedge clk_sys);
    ack0 <= 1'b0;
    look({2'b10, 2'b00, 16'h0002});
    @(posedge clk_sys);
    ack1 <= 1'b1;
    @(posedge clk_sys);
    ack1 <= 1'b0;
    get(3'h6, 8'h00);
    repeat (3) @(posedge clk_sys);
    give_verdict();
  end
endmodule

/* tb/ext_pin_model.sv */
// external pin model: each pin follows the level the bench asks for
module ext_pin_model
  import ext_irq_pkg::*;
(
  input  wire logic               clk,
  input  wire logic [NUM_SRC-1:0] want,
  output logic      [NUM_SRC-1:0] pins = '1
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins change just after an edge, like a board input resynchronised
  always_ff @(posedge clk)
  begin
    pins <= want;
  end
endmodule
